// [src/sbb_cpu_bus.sv]
// processor-board side of the backplane bus: cycles, status and handshakes
`timescale 1ns/1ps
`include "sbb_map.svh"

// Functional notes
// - status float input tristates eight status lines
// - command float input tristates six command lines
// - address float input tristates sixteen address lines
// - data-out float input tristates eight data lines
// - hold request answered by hold acknowledge
// - wait flag shown while in wait
// - interrupt-enabled output mirrors enable flip-flop
// - no interrupt acknowledge while enable cleared
// - fetch status only in opcode fetch cycle
// - output status, port address, data with write
// - input status while port address driven
// - memory read status on memory read cycles
// - halt acknowledge after halt instruction
// - bus clock is inverted master oscillator
// - memory stores data on write strobe
// - low ready holds processor in wait
// - interrupt sampled at instruction end or halt
// - interrupt ignored in hold or disabled
// - hold granted after current machine cycle
// - reset clears program counter and instruction
// - barred signals active low, rest high
// - low external ready forces wait state
module sbb_cpu_bus import sbb_pkg::*; #(
	parameter int CLK_HZ = `SBB_CLK_HZ,
	parameter int OSC_HZ = `SBB_OSC_HZ
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic status_lines_float_n_in,
	input wire logic command_lines_float_n_in,
	input wire logic address_lines_float_n_in,
	input wire logic data_out_float_n_in,
	input wire logic bus_hold_request_in,
	input wire logic processor_ready_in,
	input wire logic external_ready_in,
	input wire logic interrupt_request_in,
	input wire logic bus_reset_n_in,
	input wire logic protect_state_in,
	input wire logic [7:0] data_in,
	output logic [7:0] status_out,
	output logic status_oe_out,
	output logic status_latch_strobe_n_out,
	output logic data_in_strobe_out,
	output logic write_strobe_n_out,
	output logic hold_acknowledge_out,
	output logic wait_state_flag_out,
	output logic interrupt_enabled_flag_out,
	output logic command_oe_out,
	output logic memory_write_strobe_out,
	output logic [15:0] address_out,
	output logic address_oe_out,
	output logic [7:0] data_out,
	output logic data_oe_out,
	output logic bus_clock_out,
	output logic io_card_clear_n_out
);
	localparam int DIV = CLK_HZ / OSC_HZ;
	localparam int SW = 18;

	if (DIV < 2) begin : g_div_check
		$error("clock too slow for the bus oscillator");
	end

	logic rst_s1;
	logic rst_n;
	logic [SW-1:0] pin_s1;
	logic [SW-1:0] pin_s2;
	logic stat_float;
	logic cmd_float;
	logic addr_float;
	logic do_float;
	logic hold_s;
	logic processor_ready_in_s;
	logic external_ready_in_s;
	logic int_s;
	logic bus_reset;
	logic prot_s;
	logic [7:0] din_s;
	logic osc;
	logic tick;
	sbb_state_t state;
	logic pend;
	logic last;
	logic inte;
	logic int_ack;
	logic [2:0] cyc_type;
	logic [15:0] cyc_addr;
	logic [7:0] cyc_data;
	logic [15:0] pc;
	logic [7:0] ir;
	logic [7:0] rd_data;
	logic ready;
	logic int_take;
	logic cmd_wr;
	logic is_write;
	logic is_read;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// every bus pin crosses two flops; only the second is read
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {status_lines_float_n_in,
				command_lines_float_n_in,
				address_lines_float_n_in,
				data_out_float_n_in, bus_hold_request_in,
				processor_ready_in, external_ready_in,
				interrupt_request_in, bus_reset_n_in,
				protect_state_in, data_in};
			pin_s2 <= pin_s1;
		end
	end

	// float and reset pins are active low on the bus
	assign stat_float = !pin_s2[17];
	assign cmd_float = !pin_s2[16];
	assign addr_float = !pin_s2[15];
	assign do_float = !pin_s2[14];
	assign hold_s = pin_s2[13];
	assign processor_ready_in_s = pin_s2[12];
	assign external_ready_in_s = pin_s2[11];
	assign int_s = pin_s2[10];
	assign bus_reset = !pin_s2[9];
	assign prot_s = pin_s2[8];
	assign din_s = pin_s2[7:0];

	sbb_osc_div #(
		.DIV(DIV)
	) sbb_osc_div_inst (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.osc_out(osc),
		.tick_out(tick)
	);

	assign bus_clock_out = !osc;

	assign ready = processor_ready_in_s && external_ready_in_s;
	assign cmd_wr = reg_wr_in && (reg_addr_in == `SBB_REG_CMD);
	assign is_write = (cyc_type == CYC_MEMWR) || (cyc_type == CYC_OUT);
	assign is_read = (cyc_type == CYC_FETCH) || (cyc_type == CYC_MEMRD)
		|| (cyc_type == CYC_IN);
	// no acknowledge while disabled or held
	assign int_take = tick && int_s && inte && !hold_s
		&& ((state == S_T3 && last) || state == S_HALT);

	// a new cycle is taken only when idle and nothing is queued
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			cyc_type <= CYC_FETCH;
			last <= 1'b0;
		end else if (cmd_wr && state == S_IDLE && !pend) begin
			pend <= 1'b1;
			cyc_type <= reg_wdata_in[`SBB_CMD_TYPE_MSB:`SBB_CMD_TYPE_LSB];
			last <= reg_wdata_in[`SBB_CMD_LAST];
		end else if (tick && state == S_IDLE && pend && !hold_s) begin
			pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cyc_addr <= '0;
			cyc_data <= '0;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `SBB_REG_CYC_ADDR)
				cyc_addr <= reg_wdata_in[15:0];
			else if (reg_addr_in == `SBB_REG_CYC_DATA)
				cyc_data <= reg_wdata_in[7:0];
		end
	end

	// machine cycle sequencer, stepped by the oscillator tick
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
		end else if (tick) begin
			case (state)
			S_IDLE: begin
				if (hold_s)
					state <= S_HOLD;
				else if (pend)
					state <= S_T1;
			end
			S_T1: begin
				state <= S_T2;
			end
			S_T2, S_TW: begin
				if (ready)
					state <= S_T3;
				else
					state <= S_TW;
			end
			S_T3: begin
				// hold is granted only at the cycle boundary
				if (hold_s)
					state <= S_HOLD;
				else if (cyc_type == CYC_HALT && !int_take)
					state <= S_HALT;
				else
					state <= S_IDLE;
			end
			S_HOLD: begin
				if (!hold_s)
					state <= S_IDLE;
			end
			S_HALT: begin
				if (hold_s)
					state <= S_HOLD;
				else if (int_take)
					state <= S_IDLE;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// status word stands from T1 to the end of the cycle, held in halt
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			status_out <= '0;
		end else if (tick && state == S_IDLE && pend && !hold_s) begin
			status_out <= '0;
			status_out[`SBB_STB_WO_N] <= !is_write;
			status_out[`SBB_STB_M1] <= (cyc_type == CYC_FETCH);
			status_out[`SBB_STB_OUT] <= (cyc_type == CYC_OUT);
			status_out[`SBB_STB_INP] <= (cyc_type == CYC_IN);
			status_out[`SBB_STB_MEMR] <= (cyc_type == CYC_FETCH)
				|| (cyc_type == CYC_MEMRD);
			status_out[`SBB_STB_HLTA] <= (cyc_type == CYC_HALT);
		end else if (tick && (state == S_T3 || state == S_HALT)) begin
			if (state == S_T3 && cyc_type == CYC_HALT && !hold_s
				&& !int_take)
				status_out <= status_out;
			else if (state == S_T3 || int_take || hold_s)
				status_out <= '0;
		end
	end

	// fetches use the program counter, other cycles the written address
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			address_out <= '0;
			data_out <= '0;
		end else if (tick && state == S_IDLE && pend && !hold_s) begin
			address_out <= (cyc_type == CYC_FETCH) ? pc : cyc_addr;
			data_out <= cyc_data;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			pc <= `SBB_PC_RESET;
		else if (bus_reset)
			pc <= `SBB_PC_RESET;
		else if (tick && state == S_T3 && cyc_type == CYC_FETCH)
			pc <= pc + 16'h0001;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			ir <= `SBB_IR_RESET;
		else if (bus_reset)
			ir <= `SBB_IR_RESET;
		else if (tick && state == S_T3 && cyc_type == CYC_FETCH)
			ir <= din_s;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			rd_data <= '0;
		else if (tick && state == S_T3 && is_read)
			rd_data <= din_s;
	end

	// taking an interrupt clears the enable, as the processor does
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			inte <= 1'b0;
		else if (int_take)
			inte <= 1'b0;
		else if (cmd_wr && reg_wdata_in[`SBB_CMD_DI])
			inte <= 1'b0;
		else if (cmd_wr && reg_wdata_in[`SBB_CMD_EI])
			inte <= 1'b1;
	end

	// sticky acknowledge; a new take beats the software clear
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			int_ack <= 1'b0;
		else if (int_take)
			int_ack <= 1'b1;
		else if (reg_wr_in && reg_addr_in == `SBB_REG_STATUS
			&& reg_wdata_in[`SBB_ST_INTACK])
			int_ack <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			io_card_clear_n_out <= 1'b0;
		else
			io_card_clear_n_out <= !bus_reset;
	end

	assign status_oe_out = !stat_float;
	assign command_oe_out = !cmd_float;
	// address and data let go while the bus is granted away
	assign address_oe_out = !addr_float && state != S_HOLD;
	assign data_oe_out = !do_float && state != S_HOLD
		&& is_write && state != S_IDLE;
	assign status_latch_strobe_n_out = (state != S_T1);
	assign data_in_strobe_out = is_read
		&& (state == S_T2 || state == S_TW || state == S_T3);
	assign write_strobe_n_out = !(state == S_T3 && is_write);
	assign memory_write_strobe_out = state == S_T3
		&& cyc_type == CYC_MEMWR;
	assign hold_acknowledge_out = (state == S_HOLD);
	assign wait_state_flag_out = (state == S_TW)
		|| (state == S_HALT);
	assign interrupt_enabled_flag_out = inte;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_out <= '0;
		end else begin
			reg_rdata_out <= '0;
			if (reg_rd_in) begin
				if (reg_addr_in == `SBB_REG_CYC_ADDR) begin
					reg_rdata_out[15:0] <= cyc_addr;
				end else if (reg_addr_in == `SBB_REG_CYC_DATA) begin
					reg_rdata_out[7:0] <= cyc_data;
				end else if (reg_addr_in == `SBB_REG_STATUS) begin
					reg_rdata_out[`SBB_ST_BUSY] <= pend
						|| (state != S_IDLE && state != S_HOLD);
					reg_rdata_out[`SBB_ST_WAIT] <= wait_state_flag_out;
					reg_rdata_out[`SBB_ST_HLDA] <= hold_acknowledge_out;
					reg_rdata_out[`SBB_ST_INTE] <= inte;
					reg_rdata_out[`SBB_ST_HALT] <= (state == S_HALT);
					reg_rdata_out[`SBB_ST_INTACK] <= int_ack;
					reg_rdata_out[`SBB_ST_PROT] <= prot_s;
					reg_rdata_out[`SBB_ST_RD_LSB+:8] <= rd_data;
				end else if (reg_addr_in == `SBB_REG_PC_IR) begin
					reg_rdata_out[23:0] <= {ir, pc};
				end
			end
		end
	end

	property p_stat_float;
		@(posedge clk_in) disable iff (!rst_n)
		!status_lines_float_n_in ##2 1 |-> !status_oe_out;
	endproperty
	a_stat_float: assert property (p_stat_float)
		else $error("status drivers on while floated");

	property p_cmd_float;
		@(posedge clk_in) disable iff (!rst_n)
		!command_lines_float_n_in ##2 1 |-> !command_oe_out;
	endproperty
	a_cmd_float: assert property (p_cmd_float)
		else $error("command drivers on while floated");

	property p_addr_float;
		@(posedge clk_in) disable iff (!rst_n)
		(addr_float || hold_acknowledge_out) |-> !address_oe_out;
	endproperty
	a_addr_float: assert property (p_addr_float)
		else $error("address drivers on while floated");

	property p_do_float;
		@(posedge clk_in) disable iff (!rst_n)
		data_oe_out |-> !do_float && is_write && !hold_acknowledge_out;
	endproperty
	a_do_float: assert property (p_do_float)
		else $error("data out driven when it must float");

	property p_hold;
		@(posedge clk_in) disable iff (!rst_n)
		tick && hold_s && state == S_IDLE |=> hold_acknowledge_out
			&& !address_oe_out;
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold not acknowledged");

	property p_wait;
		@(posedge clk_in) disable iff (!rst_n)
		tick && state == S_T2 && !ready |=> wait_state_flag_out [*3];
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait flag missing while stalled");

	property p_ei;
		@(posedge clk_in) disable iff (!rst_n)
		cmd_wr && reg_wdata_in[`SBB_CMD_EI] && !reg_wdata_in[`SBB_CMD_DI]
			&& !int_take |=> interrupt_enabled_flag_out;
	endproperty
	a_ei: assert property (p_ei)
		else $error("enable instruction not mirrored");

	property p_no_ack;
		@(posedge clk_in) disable iff (!rst_n)
		$rose(int_ack) |-> $past(inte) && !$past(hold_s);
	endproperty
	a_no_ack: assert property (p_no_ack)
		else $error("interrupt taken while disabled or held");

	property p_fetch;
		@(posedge clk_in) disable iff (!rst_n)
		status_out[`SBB_STB_M1] |-> cyc_type == CYC_FETCH
			&& state != S_IDLE;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch status outside a fetch cycle");

	property p_halt;
		@(posedge clk_in) disable iff (!rst_n)
		state == S_HALT |-> status_out[`SBB_STB_HLTA];
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt state without halt acknowledge");

	property p_reset;
		@(posedge clk_in) disable iff (!rst_n)
		bus_reset |=> pc == `SBB_PC_RESET && ir == `SBB_IR_RESET;
	endproperty
	a_reset: assert property (p_reset)
		else $error("counter or instruction not cleared in reset");
endmodule : sbb_cpu_bus

// [src/sbb_map.svh]
// offsets, fields, reset values and timing for the backplane bus block
`ifndef SBB_MAP_SVH
`define SBB_MAP_SVH

`define SBB_CLK_HZ 50000000
`define SBB_OSC_HZ 2000000

`define SBB_REG_CYC_ADDR 8'h00
`define SBB_REG_CYC_DATA 8'h04
`define SBB_REG_CMD 8'h08
`define SBB_REG_STATUS 8'h0C
`define SBB_REG_PC_IR 8'h10

`define SBB_CMD_TYPE_LSB 0
`define SBB_CMD_TYPE_MSB 2
`define SBB_CMD_LAST 3
`define SBB_CMD_EI 4
`define SBB_CMD_DI 5

`define SBB_ST_BUSY 0
`define SBB_ST_WAIT 1
`define SBB_ST_HLDA 2
`define SBB_ST_INTE 3
`define SBB_ST_HALT 4
`define SBB_ST_INTACK 5
`define SBB_ST_PROT 6
`define SBB_ST_RD_LSB 8

`define SBB_STB_INTA 0
`define SBB_STB_WO_N 1
`define SBB_STB_HLTA 3
`define SBB_STB_OUT 4
`define SBB_STB_M1 5
`define SBB_STB_INP 6
`define SBB_STB_MEMR 7

`define SBB_PC_RESET 16'h0000
`define SBB_IR_RESET 8'h00

`endif

// [src/sbb_pkg.sv]
// types shared by the backplane bus block
package sbb_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_T1 = 3'h1,
		S_T2 = 3'h3,
		S_T3 = 3'h2,
		S_TW = 3'h7,
		S_HOLD = 3'h4,
		S_HALT = 3'h6
	} sbb_state_t;
	typedef enum logic [2:0] {
		CYC_FETCH = 3'h0,
		CYC_MEMRD = 3'h1,
		CYC_MEMWR = 3'h2,
		CYC_IN = 3'h3,
		CYC_OUT = 3'h4,
		CYC_HALT = 3'h5
	} sbb_cyc_t;
endpackage : sbb_pkg

// [src/sbb_osc_div.sv]
// master oscillator divider: square wave and one-cycle phase tick
`timescale 1ns/1ps
module sbb_osc_div #(
	parameter int DIV = 25
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	output logic osc_out,
	output logic tick_out
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2);
	logic [CW-1:0] cnt;

	// checked while elaborating, so a bad divisor never builds
	if (DIV < 2) begin : g_div_check
		$error("divider needs at least two cycles");
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cnt <= '0;
		else if (cnt == LAST)
			cnt <= '0;
		else
			cnt <= cnt + 1'b1;
	end

	// high for the first half; odd divisors give the extra cycle low
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			osc_out <= 1'b0;
		else
			osc_out <= (cnt == LAST) || (cnt < HALF - 1'b1);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			tick_out <= 1'b0;
		else
			tick_out <= (cnt == LAST);
	end
endmodule : sbb_osc_div

// [dv/sbb_card_model.sv]
// behavioural memory and port card on the far side of the backplane
`timescale 1ns/1ps
module sbb_card_model (
	input wire logic clk_in,
	input wire logic io_card_clear_n_in,
	input wire logic [15:0] address_in,
	input wire logic [7:0] data_out_in,
	input wire logic [7:0] status_in,
	input wire logic status_latch_strobe_n_in,
	input wire logic data_in_strobe_in,
	input wire logic memory_write_strobe_in,
	input wire logic [7:0] stall_in,
	output logic [7:0] data_in_out,
	output logic protect_state_out,
	output logic processor_ready_out
);
	logic [7:0] mem [0:255];
	logic [7:0] st_q;
	logic [7:0] stall_cnt;
	initial begin
		data_in_out = 8'h00;
		for (int k = 0; k < 256; k++) begin
			mem[k] = 8'(k) ^ 8'h5A;
		end
	end
	always @(posedge clk_in) begin
		if (memory_write_strobe_in) begin
			mem[address_in[7:0]] <= data_out_in;
		end
	end
	always @(posedge clk_in) begin
		if (!io_card_clear_n_in) begin
			st_q <= 8'h00;
			stall_cnt <= 8'h00;
		end else if (!status_latch_strobe_n_in) begin
			st_q <= status_in;
			stall_cnt <= stall_in;
		end else if (stall_cnt != 8'h00) begin
			stall_cnt <= stall_cnt - 8'h01;
		end
	end
	// released bus toggles so a stale byte never reads as valid
	always @(posedge clk_in) begin
		if (data_in_strobe_in && st_q[7]) begin
			data_in_out <= mem[address_in[7:0]];
		end else if (data_in_strobe_in && st_q[6]) begin
			data_in_out <= address_in[7:0] ^ 8'hA5;
		end else begin
			data_in_out <= ~data_in_out;
		end
	end
	assign protect_state_out = address_in[15];
	assign processor_ready_out = (stall_cnt == 8'h00);
endmodule : sbb_card_model

// [dv/sbb_cpu_bus_tb.sv]
// self-checking bench for the processor-board backplane block
`timescale 1ns/1ps
module sbb_cpu_bus_tb;
	localparam int DIV = 4;
	logic clk_in, arst_n_in, reg_wr_in, reg_rd_in;
	logic [7:0] reg_addr_in, data_in, data_out, status_out, stall;
	logic [31:0] reg_wdata_in, reg_rdata_out, m_now;
	logic status_lines_float_n_in, command_lines_float_n_in;
	logic address_lines_float_n_in, data_out_float_n_in;
	logic bus_hold_request_in, processor_ready_in, external_ready_in;
	logic interrupt_request_in, bus_reset_n_in, protect_state_in;
	logic status_oe_out, status_latch_strobe_n_out, data_in_strobe_out;
	logic write_strobe_n_out, hold_acknowledge_out, wait_state_flag_out;
	logic interrupt_enabled_flag_out, command_oe_out, memory_write_strobe_out;
	logic [15:0] address_out;
	logic address_oe_out, data_oe_out, bus_clock_out, io_card_clear_n_out;
	logic [3:0] fl;
	logic [31:0] exp_q [$];
	logic [31:0] msk_q [$];
	logic rd_pend = 1'b0;
	int error_cnt = 0;
	int checks = 0;
	int cyc_cnt = 0;
	assign {status_lines_float_n_in, command_lines_float_n_in,
		address_lines_float_n_in, data_out_float_n_in} = fl;
	sbb_cpu_bus #(.OSC_HZ(12500000)) sbb_cpu_bus_inst (.clk_in, .arst_n_in,
		.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.status_lines_float_n_in, .command_lines_float_n_in,
		.address_lines_float_n_in, .data_out_float_n_in, .bus_hold_request_in,
		.processor_ready_in, .external_ready_in, .interrupt_request_in,
		.bus_reset_n_in, .protect_state_in, .data_in, .status_out,
		.status_oe_out, .status_latch_strobe_n_out, .data_in_strobe_out,
		.write_strobe_n_out, .hold_acknowledge_out, .wait_state_flag_out,
		.interrupt_enabled_flag_out, .command_oe_out, .memory_write_strobe_out,
		.address_out, .address_oe_out, .data_out, .data_oe_out,
		.bus_clock_out, .io_card_clear_n_out);
	sbb_card_model sbb_card_model_inst (.clk_in,
		.io_card_clear_n_in(io_card_clear_n_out), .address_in(address_out),
		.data_out_in(data_out), .status_in(status_out),
		.status_latch_strobe_n_in(status_latch_strobe_n_out),
		.data_in_strobe_in(data_in_strobe_out), .stall_in(stall),
		.memory_write_strobe_in(memory_write_strobe_out),
		.data_in_out(data_in), .protect_state_out(protect_state_in),
		.processor_ready_out(processor_ready_in));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// read data stands only in the cycle after the strobe
	always @(posedge clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			report_and_stop();
		end
		if (rd_pend) begin
			m_now = msk_q.pop_front();
			chk(reg_rdata_out & m_now, exp_q.pop_front());
		end
		rd_pend <= reg_rd_in;
	end
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= wr;
		reg_rd_in <= !wr;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask : rd
	function automatic logic sig(input int s);
		case (s)
			0: return !status_latch_strobe_n_out;
			1: return !write_strobe_n_out;
			2: return wait_state_flag_out;
			3: return hold_acknowledge_out;
			default: return !wait_state_flag_out;
		endcase
	endfunction : sig
	task automatic wait_sig(input int s);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (sig(s) !== 1'b1 && n < 200);
		if (n == 200) begin
			error_cnt++;
			$display("Error at %0t ns: wait timed out", $time);
		end
	endtask : wait_sig
	task automatic cyc(input logic [7:0] c);
		bus(1'b1, 8'h08, {24'h0, c});
		wait_sig(0);
		@(negedge clk_in);
	endtask : cyc
	task automatic fin();
		wait_sig(4);
		repeat (3 * DIV + 4) @(negedge clk_in);
	endtask : fin
	initial begin
		int i, n, k;
		logic pb;
		logic [15:0] a;
		logic [15:0] ad [4];
		logic [7:0] dd [4];
		arst_n_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		fl = 4'hF;
		bus_hold_request_in = 1'b0;
		external_ready_in = 1'b1;
		interrupt_request_in = 1'b0;
		bus_reset_n_in = 1'b1;
		stall = 8'h00;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		void'($urandom(32'hB5C8));
		rd(8'h10, 32'h0, 32'h00FF_FFFF);
		rd(8'h0C, 32'h0, 32'h0000_003F);
		rd(8'h14, 32'h0, 32'hFFFF_FFFF);
		pb = bus_clock_out;
		n = 0;
		k = 0;
		repeat (6 * DIV) begin
			@(negedge clk_in);
			n++;
			if (bus_clock_out && !pb) begin
				if (k > 0) chk(32'(n), 32'(DIV));
				k++;
				n = 0;
			end
			pb = bus_clock_out;
		end
		for (i = 0; i < 4; i++) begin
			a = {8'($urandom), 8'(i)};
			ad[i] = a;
			dd[i] = 8'($urandom);
			@(posedge clk_in);
			fl <= 4'hF ^ (4'h8 >> i);
			bus(1'b1, 8'h00, {16'h0, a});
			bus(1'b1, 8'h04, {24'h0, dd[i]});
			cyc(8'h02);
			chk({address_out, 8'h00, status_out & 8'hF8}, {a, 16'h0});
			wait_sig(1);
			@(negedge clk_in);
			chk(32'({status_oe_out, command_oe_out, address_oe_out,
				data_oe_out}), 32'(fl));
			chk(32'({memory_write_strobe_out, data_out}), {23'h0, 1'b1, dd[i]});
			fin();
		end
		@(posedge clk_in);
		fl <= 4'hF;
		for (i = 0; i < 4; i++) begin
			stall = (i == 1) ? 8'(5 * DIV) : 8'h00;
			bus(1'b1, 8'h00, {16'h0, ad[i]});
			if (i == 2) external_ready_in <= 1'b0;
			cyc(8'h01);
			chk(32'(status_out & 8'hF8), 32'h80);
			if (i == 1 || i == 2) begin
				wait_sig(2);
				repeat (2 * DIV) @(negedge clk_in);
				chk(32'(wait_state_flag_out), 32'h1);
				@(posedge clk_in);
				external_ready_in <= 1'b1;
			end
			fin();
			rd(8'h0C, {16'h0, dd[i], 8'h00}, 32'h0000_FF00);
		end
		stall = 8'h00;
		cyc(8'h08);
		chk({address_out, 8'h00, status_out & 8'hF8}, 32'hA0);
		fin();
		rd(8'h10, {8'h0, dd[0], 16'h0001}, 32'h00FF_FFFF);
		a = 16'($urandom);
		bus(1'b1, 8'h00, {16'h0, a});
		cyc(8'h04);
		chk({address_out, 8'h00, status_out & 8'hF8}, {a, 16'h10});
		wait_sig(1);
		chk(32'(data_out), {24'h0, dd[3]});
		fin();
		cyc(8'h03);
		chk({address_out, 8'h00, status_out & 8'hF8}, {a, 16'h40});
		fin();
		rd(8'h0C, {16'h0, a[7:0] ^ 8'hA5, 1'b0, a[15], 6'h0},
			32'h0000_FF40);
		@(posedge clk_in);
		interrupt_request_in <= 1'b1;
		cyc(8'h11);
		fin();
		chk(32'(interrupt_enabled_flag_out), 32'h1);
		rd(8'h0C, 32'h08, 32'h0000_0028);
		cyc(8'h19);
		fin();
		rd(8'h0C, 32'h20, 32'h0000_0028);
		bus(1'b1, 8'h0C, 32'h20);
		rd(8'h0C, 32'h0, 32'h0000_0020);
		cyc(8'h05);
		chk(32'(status_out[3]), 32'h1);
		repeat (4 * DIV) @(negedge clk_in);
		chk(32'(wait_state_flag_out), 32'h1);
		rd(8'h0C, 32'h10, 32'h0000_0030);
		// enable while halted is not a cycle start
		bus(1'b1, 8'h08, 32'h10);
		repeat (DIV + 4) @(negedge clk_in);
		rd(8'h0C, 32'h20, 32'h0000_0038);
		bus(1'b1, 8'h0C, 32'h20);
		cyc(8'h19);
		@(posedge clk_in);
		bus_hold_request_in <= 1'b1;
		repeat (DIV) @(negedge clk_in);
		chk(32'(hold_acknowledge_out), 32'h0);
		wait_sig(3);
		chk(32'({address_oe_out, data_oe_out}), 32'h0);
		rd(8'h0C, 32'h0C, 32'h0000_002C);
		@(posedge clk_in);
		bus_hold_request_in <= 1'b0;
		interrupt_request_in <= 1'b0;
		repeat (3 * DIV) @(negedge clk_in);
		chk(32'(hold_acknowledge_out), 32'h0);
		cyc(8'h21);
		fin();
		chk(32'(interrupt_enabled_flag_out), 32'h0);
		@(posedge clk_in);
		bus_reset_n_in <= 1'b0;
		repeat (4) @(negedge clk_in);
		chk(32'(io_card_clear_n_out), 32'h0);
		rd(8'h10, 32'h0, 32'h00FF_FFFF);
		bus_reset_n_in <= 1'b1;
		repeat (4) @(negedge clk_in);
		chk(32'(io_card_clear_n_out), 32'h1);
		repeat (3) @(posedge clk_in);
		report_and_stop();
	end
endmodule : sbb_cpu_bus_tb
